// ==== logic/bbse_regs.vh ====
`ifndef BBSE_REGS_VH
`define BBSE_REGS_VH

// Operation codes presented on op_i
`define BBSE_OP_W            6
`define BBSE_OP_BR_EQ        6'h00
`define BBSE_OP_BR_NE        6'h01
`define BBSE_OP_BR_CS        6'h02
`define BBSE_OP_BR_CC        6'h03
`define BBSE_OP_BR_SH        6'h04
`define BBSE_OP_BR_LO        6'h05
`define BBSE_OP_BR_MI        6'h06
`define BBSE_OP_BR_PL        6'h07
`define BBSE_OP_BR_GE        6'h08
`define BBSE_OP_BR_LT        6'h09
`define BBSE_OP_BR_HS        6'h0A
`define BBSE_OP_BR_HC        6'h0B
`define BBSE_OP_BR_TS        6'h0C
`define BBSE_OP_BR_TC        6'h0D
`define BBSE_OP_BR_VS        6'h0E
`define BBSE_OP_BR_VC        6'h0F
`define BBSE_OP_BR_IE        6'h10
`define BBSE_OP_BR_ID        6'h11
`define BBSE_OP_IO_SET       6'h12
`define BBSE_OP_IO_CLR       6'h13
`define BBSE_OP_SHL          6'h14
`define BBSE_OP_SHR          6'h15
`define BBSE_OP_ROL          6'h16
`define BBSE_OP_ROR          6'h17
`define BBSE_OP_ASR          6'h18
`define BBSE_OP_SWAP         6'h19
`define BBSE_OP_FLAG_SET     6'h1A
`define BBSE_OP_FLAG_CLR     6'h1B
`define BBSE_OP_BIT_TO_T     6'h1C
`define BBSE_OP_T_TO_BIT     6'h1D
`define BBSE_OP_C_SET        6'h1E
`define BBSE_OP_C_CLR        6'h1F
`define BBSE_OP_N_SET        6'h20
`define BBSE_OP_N_CLR        6'h21
`define BBSE_OP_Z_SET        6'h22
`define BBSE_OP_Z_CLR        6'h23
`define BBSE_OP_I_SET        6'h24
`define BBSE_OP_I_CLR        6'h25

// Bit positions inside the core flag register
`define BBSE_FLG_C           0
`define BBSE_FLG_Z           1
`define BBSE_FLG_N           2
`define BBSE_FLG_V           3
`define BBSE_FLG_S           4
`define BBSE_FLG_H           5
`define BBSE_FLG_T           6
`define BBSE_FLG_I           7
`define BBSE_FLAGS_RST       8'h00

// Data path layout
`define BBSE_DATA_W          8
`define BBSE_MSB             7
`define BBSE_SIGN_KEEP       6
`define BBSE_NIB_HI_MSB      7
`define BBSE_NIB_HI_LSB      4
`define BBSE_NIB_LO_MSB      3
`define BBSE_BYTE_ZERO       8'h00
`define BBSE_BIT_ONE         8'h01

// Cycle counts per instruction group
`define BBSE_CYC_BR_NOT      1
`define BBSE_CYC_BR_TAKEN    2
`define BBSE_CYC_IO          2
`define BBSE_CYC_ONE         1

`endif

// ==== logic/bbse_shift.v ====
`timescale 1ns/1ps
`include "bbse_regs.vh"

module bbse_shift (
  input  wire [`BBSE_OP_W-1:0]   op_i,
  input  wire [`BBSE_DATA_W-1:0] data_i,
  input  wire                    carry_i,
  input  wire                    t_flag_i,
  input  wire [2:0]              bit_sel_i,
  output reg  [`BBSE_DATA_W-1:0] result_o,
  output reg                     carry_o,
  output wire                    zero_o,
  output wire                    neg_o,
  output wire                    ovf_o
);

  always @* begin
    result_o = data_i;
    carry_o  = carry_i;
    case (op_i)
      `BBSE_OP_SHL: begin
        result_o = {data_i[`BBSE_MSB-1:0], 1'b0};
        carry_o  = data_i[`BBSE_MSB];
      end
      `BBSE_OP_SHR: begin
        result_o = {1'b0, data_i[`BBSE_MSB:1]};
        carry_o  = data_i[0];
      end
      `BBSE_OP_ROL: begin
        result_o = {data_i[`BBSE_MSB-1:0], carry_i};
        carry_o  = data_i[`BBSE_MSB];
      end
      `BBSE_OP_ROR: begin
        result_o = {carry_i, data_i[`BBSE_MSB:1]};
        carry_o  = data_i[0];
      end
      `BBSE_OP_ASR: begin
        result_o = {data_i[`BBSE_MSB], data_i[`BBSE_MSB:1]};
        carry_o  = data_i[0];
      end
      `BBSE_OP_SWAP: begin
        result_o = {data_i[`BBSE_NIB_LO_MSB:0], data_i[`BBSE_NIB_HI_MSB:`BBSE_NIB_HI_LSB]};
      end
      `BBSE_OP_T_TO_BIT: begin
        result_o            = data_i;
        result_o[bit_sel_i] = t_flag_i;
      end
      default: begin
        result_o = data_i;
        carry_o  = carry_i;
      end
    endcase
  end

  assign zero_o = (result_o == `BBSE_BYTE_ZERO);
  assign neg_o  = result_o[`BBSE_MSB];
  // Overflow of a one-bit shift is the new sign bit XORed with the carry out
  assign ovf_o  = result_o[`BBSE_MSB] ^ carry_o;

endmodule

// ==== logic/bbse_exec.v ====
`timescale 1ns/1ps
`include "bbse_regs.vh"

module bbse_exec #(
  parameter PC_W  = 16,
  parameter OFS_W = 7,
  parameter IO_AW = 5
) (
  input  wire                    clk_sys_i,
  input  wire                    sys_rst_i,
  input  wire                    start_i,
  input  wire [`BBSE_OP_W-1:0]   op_i,
  input  wire [PC_W-1:0]         pc_i,
  input  wire [OFS_W-1:0]        offset_i,
  input  wire [`BBSE_DATA_W-1:0] rd_data_i,
  input  wire [2:0]              bit_sel_i,
  input  wire [IO_AW-1:0]        io_addr_i,
  input  wire [`BBSE_DATA_W-1:0] io_rdata_i,
  input  wire                    flags_wr_i,
  input  wire [`BBSE_DATA_W-1:0] flags_wdata_i,
  output wire                    busy_o,
  output wire                    done_o,
  output wire                    illegal_o,
  output wire [PC_W-1:0]         pc_o,
  output wire                    pc_load_o,
  output wire [`BBSE_DATA_W-1:0] rd_wdata_o,
  output wire                    rd_we_o,
  output wire [IO_AW-1:0]        io_addr_o,
  output wire [`BBSE_DATA_W-1:0] io_wdata_o,
  output wire                    io_we_o,
  output wire [`BBSE_DATA_W-1:0] flags_o
);

  localparam ST_IDLE   = 2'b00;
  localparam ST_BRANCH = 2'b01;
  localparam ST_IO     = 2'b10;

  localparam [PC_W-1:0] PC_STEP = {{(PC_W-1){1'b0}}, 1'b1};

  reg  [1:0]              state_ff;
  reg  [1:0]              nxt_state;
  reg                     busy_ff;
  reg                     nxt_busy;
  reg                     done_ff;
  reg                     nxt_done;
  reg                     illegal_ff;
  reg                     nxt_illegal;
  reg  [PC_W-1:0]         pc_ff;
  reg  [PC_W-1:0]         nxt_pc;
  reg                     pc_load_ff;
  reg                     nxt_pc_load;
  reg  [`BBSE_DATA_W-1:0] rd_wdata_ff;
  reg  [`BBSE_DATA_W-1:0] nxt_rd_wdata;
  reg                     rd_we_ff;
  reg                     nxt_rd_we;
  reg  [IO_AW-1:0]        io_addr_ff;
  reg  [IO_AW-1:0]        nxt_io_addr;
  reg  [`BBSE_DATA_W-1:0] io_wdata_ff;
  reg  [`BBSE_DATA_W-1:0] nxt_io_wdata;
  reg                     io_we_ff;
  reg                     nxt_io_we;
  reg  [`BBSE_DATA_W-1:0] flags_ff;
  reg  [`BBSE_DATA_W-1:0] nxt_flags;

  wire                    accept;
  wire [`BBSE_DATA_W-1:0] flags_base;
  wire [PC_W-1:0]         ofs_ext;
  wire [PC_W-1:0]         br_target;
  wire [`BBSE_DATA_W-1:0] sh_result;
  wire                    sh_carry;
  wire                    sh_zero;
  wire                    sh_neg;
  wire                    sh_ovf;

  // One-hot mask for a bit number, shared by I/O and flag operations
  function [`BBSE_DATA_W-1:0] bit_mask;
    input [2:0] sel;
    begin
      bit_mask = `BBSE_BIT_ONE << sel;
    end
  endfunction

  // Returns 1 for a branch opcode whose tested condition holds
  function branch_take;
    input [`BBSE_OP_W-1:0]   op;
    input [`BBSE_DATA_W-1:0] f;
    begin
      case (op)
        `BBSE_OP_BR_EQ: branch_take = f[`BBSE_FLG_Z];
        `BBSE_OP_BR_NE: branch_take = ~f[`BBSE_FLG_Z];
        `BBSE_OP_BR_CS: branch_take = f[`BBSE_FLG_C];
        `BBSE_OP_BR_LO: branch_take = f[`BBSE_FLG_C];
        `BBSE_OP_BR_CC: branch_take = ~f[`BBSE_FLG_C];
        `BBSE_OP_BR_SH: branch_take = ~f[`BBSE_FLG_C];
        `BBSE_OP_BR_MI: branch_take = f[`BBSE_FLG_N];
        `BBSE_OP_BR_PL: branch_take = ~f[`BBSE_FLG_N];
        `BBSE_OP_BR_GE: branch_take = ~(f[`BBSE_FLG_N] ^ f[`BBSE_FLG_V]);
        `BBSE_OP_BR_LT: branch_take = f[`BBSE_FLG_N] ^ f[`BBSE_FLG_V];
        `BBSE_OP_BR_HS: branch_take = f[`BBSE_FLG_H];
        `BBSE_OP_BR_HC: branch_take = ~f[`BBSE_FLG_H];
        `BBSE_OP_BR_TS: branch_take = f[`BBSE_FLG_T];
        `BBSE_OP_BR_TC: branch_take = ~f[`BBSE_FLG_T];
        `BBSE_OP_BR_VS: branch_take = f[`BBSE_FLG_V];
        `BBSE_OP_BR_VC: branch_take = ~f[`BBSE_FLG_V];
        `BBSE_OP_BR_IE: branch_take = f[`BBSE_FLG_I];
        `BBSE_OP_BR_ID: branch_take = ~f[`BBSE_FLG_I];
        default:        branch_take = 1'b0;
      endcase
    end
  endfunction

  function is_branch;
    input [`BBSE_OP_W-1:0] op;
    begin
      is_branch = (op <= `BBSE_OP_BR_ID);
    end
  endfunction

  // Requests are only taken while idle; a start during a two-cycle op is dropped
  assign accept     = start_i & (state_ff == ST_IDLE);
  // A flag write from the rest of the core lands first, an op in the same cycle builds on it
  assign flags_base = flags_wr_i ? flags_wdata_i : flags_ff;

  assign ofs_ext   = {{(PC_W-OFS_W){offset_i[OFS_W-1]}}, offset_i};
  assign br_target = pc_i + ofs_ext + PC_STEP;

  bbse_shift u_shift (
    .op_i      (op_i),
    .data_i    (rd_data_i),
    .carry_i   (flags_base[`BBSE_FLG_C]),
    .t_flag_i  (flags_base[`BBSE_FLG_T]),
    .bit_sel_i (bit_sel_i),
    .result_o  (sh_result),
    .carry_o   (sh_carry),
    .zero_o    (sh_zero),
    .neg_o     (sh_neg),
    .ovf_o     (sh_ovf)
  );

  always @* begin
    nxt_state    = state_ff;
    nxt_done     = 1'b0;
    nxt_illegal  = 1'b0;
    nxt_pc       = pc_ff;
    nxt_pc_load  = 1'b0;
    nxt_rd_wdata = rd_wdata_ff;
    nxt_rd_we    = 1'b0;
    nxt_io_addr  = io_addr_ff;
    nxt_io_wdata = io_wdata_ff;
    nxt_io_we    = 1'b0;
    nxt_flags    = flags_base;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          if (is_branch(op_i)) begin
            // Branches never write flags
            if (branch_take(op_i, flags_base)) begin
              nxt_pc    = br_target;
              nxt_state = ST_BRANCH;
            end else begin
              nxt_done = 1'b1;
            end
          end else begin
            case (op_i)
              `BBSE_OP_IO_SET: begin
                nxt_io_addr  = io_addr_i;
                nxt_io_wdata = io_rdata_i | bit_mask(bit_sel_i);
                nxt_state    = ST_IO;
              end
              `BBSE_OP_IO_CLR: begin
                nxt_io_addr  = io_addr_i;
                nxt_io_wdata = io_rdata_i & ~bit_mask(bit_sel_i);
                nxt_state    = ST_IO;
              end
              `BBSE_OP_SHL, `BBSE_OP_SHR, `BBSE_OP_ASR: begin
                nxt_rd_wdata              = sh_result;
                nxt_rd_we                 = 1'b1;
                nxt_flags[`BBSE_FLG_C]    = sh_carry;
                nxt_flags[`BBSE_FLG_Z]    = sh_zero;
                nxt_flags[`BBSE_FLG_N]    = sh_neg;
                nxt_flags[`BBSE_FLG_V]    = sh_ovf;
                nxt_done                  = 1'b1;
              end
              `BBSE_OP_ROL, `BBSE_OP_ROR: begin
                nxt_rd_wdata              = sh_result;
                nxt_rd_we                 = 1'b1;
                nxt_flags[`BBSE_FLG_C]    = sh_carry;
                nxt_flags[`BBSE_FLG_Z]    = sh_zero;
                nxt_flags[`BBSE_FLG_N]    = sh_neg;
                nxt_flags[`BBSE_FLG_V]    = sh_ovf;
                nxt_done                  = 1'b1;
              end
              `BBSE_OP_SWAP: begin
                nxt_rd_wdata = sh_result;
                nxt_rd_we    = 1'b1;
                nxt_done     = 1'b1;
              end
              `BBSE_OP_T_TO_BIT: begin
                nxt_rd_wdata = sh_result;
                nxt_rd_we    = 1'b1;
                nxt_done     = 1'b1;
              end
              `BBSE_OP_BIT_TO_T: begin
                nxt_flags[`BBSE_FLG_T] = rd_data_i[bit_sel_i];
                nxt_done               = 1'b1;
              end
              `BBSE_OP_FLAG_SET: begin
                nxt_flags = flags_base | bit_mask(bit_sel_i);
                nxt_done  = 1'b1;
              end
              `BBSE_OP_FLAG_CLR: begin
                nxt_flags = flags_base & ~bit_mask(bit_sel_i);
                nxt_done  = 1'b1;
              end
              `BBSE_OP_C_SET: begin
                nxt_flags[`BBSE_FLG_C] = 1'b1;
                nxt_done               = 1'b1;
              end
              `BBSE_OP_C_CLR: begin
                nxt_flags[`BBSE_FLG_C] = 1'b0;
                nxt_done               = 1'b1;
              end
              `BBSE_OP_N_SET: begin
                nxt_flags[`BBSE_FLG_N] = 1'b1;
                nxt_done               = 1'b1;
              end
              `BBSE_OP_N_CLR: begin
                nxt_flags[`BBSE_FLG_N] = 1'b0;
                nxt_done               = 1'b1;
              end
              `BBSE_OP_Z_SET: begin
                nxt_flags[`BBSE_FLG_Z] = 1'b1;
                nxt_done               = 1'b1;
              end
              `BBSE_OP_Z_CLR: begin
                nxt_flags[`BBSE_FLG_Z] = 1'b0;
                nxt_done               = 1'b1;
              end
              `BBSE_OP_I_SET: begin
                nxt_flags[`BBSE_FLG_I] = 1'b1;
                nxt_done               = 1'b1;
              end
              `BBSE_OP_I_CLR: begin
                nxt_flags[`BBSE_FLG_I] = 1'b0;
                nxt_done               = 1'b1;
              end
              default: begin
                // Unknown code finishes at once and reports itself
                nxt_illegal = 1'b1;
                nxt_done    = 1'b1;
              end
            endcase
          end
        end
      end
      ST_BRANCH: begin
        // Second cycle of a taken branch hands the target to the fetch side
        nxt_pc_load = 1'b1;
        nxt_done    = 1'b1;
        nxt_state   = ST_IDLE;
      end
      ST_IO: begin
        // Read-modify-write: only the chosen bit differs from what was read
        nxt_io_we = 1'b1;
        nxt_done  = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Busy is registered so the output comes straight from a flop
    nxt_busy     = (nxt_state != ST_IDLE);
  end

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff    <= ST_IDLE;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      illegal_ff  <= 1'b0;
      pc_ff       <= {PC_W{1'b0}};
      pc_load_ff  <= 1'b0;
      rd_wdata_ff <= `BBSE_BYTE_ZERO;
      rd_we_ff    <= 1'b0;
      io_addr_ff  <= {IO_AW{1'b0}};
      io_wdata_ff <= `BBSE_BYTE_ZERO;
      io_we_ff    <= 1'b0;
      flags_ff    <= `BBSE_FLAGS_RST;
    end else begin
      state_ff    <= nxt_state;
      busy_ff     <= nxt_busy;
      done_ff     <= nxt_done;
      illegal_ff  <= nxt_illegal;
      pc_ff       <= nxt_pc;
      pc_load_ff  <= nxt_pc_load;
      rd_wdata_ff <= nxt_rd_wdata;
      rd_we_ff    <= nxt_rd_we;
      io_addr_ff  <= nxt_io_addr;
      io_wdata_ff <= nxt_io_wdata;
      io_we_ff    <= nxt_io_we;
      flags_ff    <= nxt_flags;
    end
  end

  assign busy_o     = busy_ff;
  assign done_o     = done_ff;
  assign illegal_o  = illegal_ff;
  assign pc_o       = pc_ff;
  assign pc_load_o  = pc_load_ff;
  assign rd_wdata_o = rd_wdata_ff;
  assign rd_we_o    = rd_we_ff;
  assign io_addr_o  = io_addr_ff;
  assign io_wdata_o = io_wdata_ff;
  assign io_we_o    = io_we_ff;
  assign flags_o    = flags_ff;

endmodule

// ==== verif/bbse_exec_chk.sv ====
`timescale 1ns/1ps
`include "bbse_regs.vh"
module bbse_exec_chk #(
  parameter PC_W  = 16,
  parameter OFS_W = 7,
  parameter IO_AW = 5
) (
  input wire                    clk_sys_i,
  input wire                    sys_rst_i,
  input wire                    start_i,
  input wire [`BBSE_OP_W-1:0]   op_i,
  input wire [PC_W-1:0]         pc_i,
  input wire [OFS_W-1:0]        offset_i,
  input wire [`BBSE_DATA_W-1:0] rd_data_i,
  input wire [2:0]              bit_sel_i,
  input wire [`BBSE_DATA_W-1:0] io_rdata_i,
  input wire                    flags_wr_i,
  input wire [`BBSE_DATA_W-1:0] flags_wdata_i,
  input wire                    busy_o,
  input wire                    done_o,
  input wire                    illegal_o,
  input wire [PC_W-1:0]         pc_o,
  input wire                    pc_load_o,
  input wire [`BBSE_DATA_W-1:0] rd_wdata_o,
  input wire                    rd_we_o,
  input wire [`BBSE_DATA_W-1:0] io_wdata_o,
  input wire                    io_we_o,
  input wire [`BBSE_DATA_W-1:0] flags_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // External flag write lands before the op, so every expectation that reads the flags starts from the merged value
  wire            acc   = start_i & ~busy_o;
  wire [7:0]      fmrg  = flags_wr_i ? flags_wdata_i : flags_o;
  wire [PC_W-1:0] tgt   = pc_i + {{(PC_W-OFS_W){offset_i[OFS_W-1]}}, offset_i} + {{(PC_W-1){1'b0}}, 1'b1};
  wire [7:0]      bmask = 8'h01 << bit_sel_i;
  wire [7:0]      io_s  = io_rdata_i | bmask;
  wire [7:0]      io_c  = io_rdata_i & ~bmask;
  wire [7:0]      t_fl  = {fmrg[7], rd_data_i[bit_sel_i], fmrg[5:0]};
  wire [8:0]      shl_x = {rd_data_i, 1'b0};
  wire [8:0]      ror_x = {fmrg[`BBSE_FLG_C], rd_data_i};
  wire [7:0]      swp   = {rd_data_i[3:0], rd_data_i[7:4]};
  sequence take_s(logic [5:0] o); acc && op_i == o; endsequence
  sequence br_s; acc && op_i <= `BBSE_OP_BR_ID; endsequence
  sequence slow_br_s; busy_o && !done_o ##1 done_o && pc_load_o && !busy_o; endsequence
  br_target_a: assert property (br_s ##1 busy_o |-> pc_o == $past(tgt))
    else $error("branch target wrong");
  br_time_a: assert property (br_s |=> (done_o && !busy_o && !pc_load_o) or slow_br_s)
    else $error("branch timing wrong");
  br_flags_a: assert property (br_s |=> flags_o == $past(fmrg))
    else $error("branch changed flags");
  io_set_a: assert property (take_s(`BBSE_OP_IO_SET) |=> busy_o ##1 io_we_o && done_o && io_wdata_o == $past(io_s, 2))
    else $error("io set wrong");
  io_clr_a: assert property (take_s(`BBSE_OP_IO_CLR) |=> busy_o ##1 io_we_o && done_o && io_wdata_o == $past(io_c, 2))
    else $error("io clear wrong");
  shl_res_a: assert property (take_s(`BBSE_OP_SHL) |=> rd_we_o && {flags_o[`BBSE_FLG_C], rd_wdata_o} == $past(shl_x))
    else $error("left shift wrong");
  ror_res_a: assert property (take_s(`BBSE_OP_ROR) |=> rd_we_o && {rd_wdata_o, flags_o[`BBSE_FLG_C]} == $past(ror_x))
    else $error("rotate right wrong");
  swap_res_a: assert property (take_s(`BBSE_OP_SWAP) |=> rd_we_o && rd_wdata_o == $past(swp) && flags_o == $past(fmrg))
    else $error("swap wrong");
  bst_flag_a: assert property (take_s(`BBSE_OP_BIT_TO_T) |=> flags_o == $past(t_fl))
    else $error("bit store wrong");
  one_cycle_a: assert property (acc && op_i >= `BBSE_OP_SHL |=> done_o && !busy_o)
    else $error("single cycle op late");
  busy_once_a: assert property (busy_o |=> !busy_o && done_o)
    else $error("busy too long");
  illegal_quiet_a: assert property (illegal_o |-> done_o && !rd_we_o && !io_we_o && !pc_load_o)
    else $error("illegal op had effects");
endmodule
bind bbse_exec bbse_exec_chk #(.PC_W(PC_W), .OFS_W(OFS_W), .IO_AW(IO_AW)) u_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .start_i(start_i), .op_i(op_i), .pc_i(pc_i),
  .offset_i(offset_i), .rd_data_i(rd_data_i), .bit_sel_i(bit_sel_i), .io_rdata_i(io_rdata_i),
  .flags_wr_i(flags_wr_i), .flags_wdata_i(flags_wdata_i), .busy_o(busy_o), .done_o(done_o),
  .illegal_o(illegal_o), .pc_o(pc_o), .pc_load_o(pc_load_o), .rd_wdata_o(rd_wdata_o),
  .rd_we_o(rd_we_o), .io_wdata_o(io_wdata_o), .io_we_o(io_we_o), .flags_o(flags_o));

// ==== verif/bbse_exec_tb.sv ====
`timescale 1ns/1ps
`include "bbse_regs.vh"
module testbench;
  reg         clk_sys_i, sys_rst_i, start_i, flags_wr_i;
  reg  [5:0]  op_i;
  reg  [15:0] pc_i;
  reg  [6:0]  offset_i;
  reg  [7:0]  rd_data_i, io_rdata_i, flags_wdata_i;
  reg  [2:0]  bit_sel_i;
  reg  [4:0]  io_addr_i;
  wire        busy_o, done_o, illegal_o, pc_load_o, rd_we_o, io_we_o;
  wire [15:0] pc_o;
  wire [7:0]  rd_wdata_o, io_wdata_o, flags_o;
  wire [4:0]  io_addr_o;
  integer     err_total, tests_run, cyc, n, i;
  reg  [31:0] seed;
  reg  [7:0]  fm;
  reg  [15:0] pe;
  reg  [16:0] e;
  reg         tk;

  bbse_exec #(.PC_W(16), .OFS_W(7), .IO_AW(5)) uut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .start_i(start_i), .op_i(op_i), .pc_i(pc_i),
    .offset_i(offset_i), .rd_data_i(rd_data_i), .bit_sel_i(bit_sel_i), .io_addr_i(io_addr_i),
    .io_rdata_i(io_rdata_i), .flags_wr_i(flags_wr_i), .flags_wdata_i(flags_wdata_i), .busy_o(busy_o),
    .done_o(done_o), .illegal_o(illegal_o), .pc_o(pc_o), .pc_load_o(pc_load_o), .rd_wdata_o(rd_wdata_o),
    .rd_we_o(rd_we_o), .io_addr_o(io_addr_o), .io_wdata_o(io_wdata_o), .io_we_o(io_we_o), .flags_o(flags_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction

  function br_taken(input [5:0] op, input [7:0] f);
    reg b;
    begin
      case (op[5:1])
        5'h0: b = f[`BBSE_FLG_Z];
        5'h1: b = f[`BBSE_FLG_C];
        5'h2: b = ~f[`BBSE_FLG_C];
        5'h3: b = f[`BBSE_FLG_N];
        5'h4: b = ~(f[`BBSE_FLG_N] ^ f[`BBSE_FLG_V]);
        5'h5: b = f[`BBSE_FLG_H];
        5'h6: b = f[`BBSE_FLG_T];
        5'h7: b = f[`BBSE_FLG_V];
        default: b = f[`BBSE_FLG_I];
      endcase
      br_taken = op[0] ? ~b : b;
    end
  endfunction

  function [15:0] shift_exp(input [5:0] op, input [7:0] d, input [7:0] f);
    reg [7:0] r, g;
    reg       c;
    begin
      case (op)
        `BBSE_OP_SHL: {c, r} = {d, 1'b0};
        `BBSE_OP_SHR: {r, c} = {1'b0, d};
        `BBSE_OP_ROL: {c, r} = {d, f[`BBSE_FLG_C]};
        `BBSE_OP_ROR: {r, c} = {f[`BBSE_FLG_C], d};
        default: {r, c} = {d[7], d};
      endcase
      g = f;
      g[`BBSE_FLG_C] = c;
      g[`BBSE_FLG_Z] = (r == 8'h00);
      g[`BBSE_FLG_N] = r[7];
      g[`BBSE_FLG_V] = r[7] ^ c;
      shift_exp = {g, r};
    end
  endfunction

  function [16:0] misc_exp(input [5:0] op, input [7:0] d, input [2:0] b, input [7:0] f);
    reg [7:0] r, g;
    reg       we;
    begin
      r = d;
      g = f;
      we = 1'b0;
      case (op)
        `BBSE_OP_SWAP: begin r = {d[3:0], d[7:4]}; we = 1'b1; end
        `BBSE_OP_FLAG_SET: g[b] = 1'b1;
        `BBSE_OP_FLAG_CLR: g[b] = 1'b0;
        `BBSE_OP_BIT_TO_T: g[`BBSE_FLG_T] = d[b];
        `BBSE_OP_T_TO_BIT: begin r[b] = f[`BBSE_FLG_T]; we = 1'b1; end
        `BBSE_OP_C_SET, `BBSE_OP_C_CLR: g[`BBSE_FLG_C] = ~op[0];
        `BBSE_OP_N_SET, `BBSE_OP_N_CLR: g[`BBSE_FLG_N] = ~op[0];
        `BBSE_OP_Z_SET, `BBSE_OP_Z_CLR: g[`BBSE_FLG_Z] = ~op[0];
        default: g[`BBSE_FLG_I] = ~op[0];
      endcase
      misc_exp = {we, g, r};
    end
  endfunction

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // Stuff keeps a second request up during the busy cycle; it must be dropped, not queued
  task run(input [5:0] op, input [15:0] pc, input [6:0] ofs, input [7:0] d, input [2:0] b,
           input [7:0] iord, input fw, input [7:0] fwd, input stuff);
    begin
      // One idle edge first, so no input is written twice in one time step
      @(posedge clk_sys_i); #1;
      start_i = 1'b1; op_i = op; pc_i = pc; offset_i = ofs; rd_data_i = d; bit_sel_i = b;
      io_rdata_i = iord; io_addr_i = seed[28:24]; flags_wr_i = fw; flags_wdata_i = fwd;
      if (fw) fm = fwd;
      @(posedge clk_sys_i); #1;
      start_i = stuff; op_i = `BBSE_OP_SWAP; flags_wr_i = 1'b0; n = 1;
      while (done_o !== 1'b1 && n < 4) begin
        @(posedge clk_sys_i); #1;
        start_i = 1'b0;
        n = n + 1;
      end
    end
  endtask

  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      finish_test;
    end
  end

  initial begin
    err_total = 0; tests_run = 0; cyc = 0; seed = 32'h092e_1fee; fm = 8'h00;
    sys_rst_i = 1'b1; start_i = 1'b0; flags_wr_i = 1'b0; op_i = 6'h00; pc_i = 16'h0000;
    offset_i = 7'h00; rd_data_i = 8'h00; io_rdata_i = 8'h00; flags_wdata_i = 8'h00;
    bit_sel_i = 3'h0; io_addr_i = 5'h00;
    repeat (12) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    chk({busy_o, done_o, pc_load_o, pc_o, flags_o}, 32'h0000_0000);
    for (i = 0; i < 72; i = i + 1) begin
      seed = xs(seed);
      pe = (i >= 54) ? 16'hffff : seed[31:16];
      e[6:0] = (i < 18) ? 7'h40 : seed[14:8];
      tk = br_taken(i % 18, seed[7:0]);
      run(i % 18, pe, e[6:0], seed[23:16], 3'h0, 8'h00, 1'b1, seed[7:0], tk & i[0]);
      chk(n, tk ? 2 : 1);
      chk(pc_load_o, tk);
      // Target wraps at the program counter width
      e[15:0] = pe + {{9{e[6]}}, e[6:0]} + 16'h0001;
      if (tk) chk(pc_o, e[15:0]);
      chk(flags_o, fm);
      if (tk & i[0]) begin
        @(posedge clk_sys_i); #1;
        chk({done_o, rd_we_o}, 0);
      end
    end
    for (i = 0; i < 40; i = i + 1) begin
      seed = xs(seed);
      run(`BBSE_OP_SHL + i % 5, 16'h0000, 7'h00, (i < 5) ? 8'h80 : seed[7:0], 3'h0, 8'h00,
          seed[16], seed[15:8], 1'b0);
      e[15:0] = shift_exp(`BBSE_OP_SHL + i % 5, (i < 5) ? 8'h80 : seed[7:0], fm);
      chk({n[7:0], rd_we_o, rd_wdata_o}, {8'd1, 1'b1, e[7:0]});
      chk(flags_o, e[15:8]);
      fm = e[15:8];
    end
    for (i = 0; i < 65; i = i + 1) begin
      seed = xs(seed);
      run(`BBSE_OP_SWAP + i % 13, 16'h0000, 7'h00, seed[7:0], seed[10:8], 8'h00,
          seed[11], seed[23:16], 1'b0);
      e = misc_exp(`BBSE_OP_SWAP + i % 13, seed[7:0], seed[10:8], fm);
      chk({n[7:0], rd_we_o}, {8'd1, e[16]});
      if (e[16]) chk(rd_wdata_o, e[7:0]);
      chk(flags_o, e[15:8]);
      fm = e[15:8];
    end
    for (i = 0; i < 16; i = i + 1) begin
      seed = xs(seed);
      run(`BBSE_OP_IO_SET + i % 2, 16'h0000, 7'h00, 8'h00, seed[2:0], seed[15:8], 1'b0, 8'h00, 1'b0);
      e[7:0] = i[0] ? (seed[15:8] & ~(8'h01 << seed[2:0])) : (seed[15:8] | (8'h01 << seed[2:0]));
      chk({n[7:0], io_we_o, io_wdata_o, io_addr_o}, {8'd2, 1'b1, e[7:0], seed[28:24]});
      chk(flags_o, fm);
    end
    run(6'h3f, 16'h0000, 7'h00, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0);
    chk({n[7:0], illegal_o, rd_we_o, io_we_o, pc_load_o, flags_o}, {8'd1, 4'b1000, fm});
    #5 sys_rst_i = 1'b1;
    @(posedge clk_sys_i); #1 sys_rst_i = 1'b0;
    chk({busy_o, done_o, flags_o}, 0);
    finish_test;
  end
endmodule
